/* core/hci_pkg.sv */
package hci_pkg;

  // Receive stream and buffering
  localparam int unsigned HCI_BYTE_W = 8;
  localparam int unsigned HCI_FIFO_DEPTH = 8;

  // Framing characters
  localparam logic [7:0] HCI_CH_ESC = 8'h1B;
  localparam logic [7:0] HCI_CH_CR = 8'h0D;
  localparam logic [7:0] HCI_CH_CTRL_B = 8'h02;
  localparam logic [7:0] HCI_CH_CTRL_P = 8'h10;
  localparam logic [7:0] HCI_CLS_KEY = 8'h54;
  localparam logic [7:0] HCI_CLS_OUT = 8'h41;
  localparam logic [7:0] HCI_CLS_SYS = 8'h53;

  // Four-character codes, held as their ASCII bytes, first character high
  localparam logic [31:0] HCI_KC_CANCEL = 32'h30313030;
  localparam logic [31:0] HCI_KC_CONFIRM = 32'h30313034;
  localparam logic [31:0] HCI_KC_AXIS1 = 32'h30313039;
  localparam logic [31:0] HCI_KC_AXIS2 = 32'h30313130;
  localparam logic [31:0] HCI_KC_AXIS3 = 32'h30313131;
  localparam logic [31:0] HCI_KC_LEFT = 32'h30313335;
  localparam logic [31:0] HCI_KC_RIGHT = 32'h30313336;
  localparam logic [31:0] HCI_KC_UP = 32'h30313337;
  localparam logic [31:0] HCI_KC_DOWN = 32'h30313338;
  localparam logic [31:0] HCI_KC_MENU = 32'h30313430;
  localparam logic [31:0] HCI_KC_UNIT = 32'h30313431;
  localparam logic [31:0] HCI_KC_ABS_INC = 32'h30313432;
  localparam logic [31:0] HCI_KC_DIA_RAD = 32'h30313433;
  localparam logic [31:0] HCI_KC_HELP = 32'h30313434;
  localparam logic [31:0] HCI_KC_REF = 32'h30313435;
  localparam logic [31:0] HCI_OC_IDENT = 32'h30303030;
  localparam logic [31:0] HCI_OC_POS = 32'h30323030;
  localparam logic [31:0] HCI_SC_RESET = 32'h30303030;
  localparam logic [31:0] HCI_SC_LOCK = 32'h30303031;
  localparam logic [31:0] HCI_SC_RELEASE = 32'h30303032;

  // Index of the last code character
  localparam logic [1:0] HCI_CODE_LAST = 2'h3;

  // Reset values
  localparam logic HCI_LOCK_RST = 1'b0;

  typedef enum logic [3:0] {
    HCI_KEY_CANCEL,
    HCI_KEY_CONFIRM,
    HCI_KEY_AXIS1,
    HCI_KEY_AXIS2,
    HCI_KEY_AXIS3,
    HCI_KEY_LEFT,
    HCI_KEY_RIGHT,
    HCI_KEY_UP,
    HCI_KEY_DOWN,
    HCI_KEY_MENU,
    HCI_KEY_UNIT_SYSTEM_TOGGLE,
    HCI_KEY_ABS_INC,
    HCI_KEY_DIA_RAD,
    HCI_KEY_HELP,
    HCI_KEY_REF_MARKS
  } hci_key_type;

  typedef enum logic [1:0] {
    HCI_ST_IDLE,
    HCI_ST_CLASS,
    HCI_ST_CODE,
    HCI_ST_TERM
  } hci_state_type;

  typedef struct packed {
    logic valid;
    logic from_host;
    hci_key_type key;
  } hci_key_evt_type;

  typedef struct packed {
    logic ident;
    logic position;
    logic screen;
    logic dev_reset;
    logic frame_err;
  } hci_req_type;

endpackage : hci_pkg

/* core/hci_core.sv */
`timescale 1ns/1ns

// Byte FIFO between the link receiver and the parser
module hci_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } hci_fifo_state_type;

  hci_fifo_state_type q;
  hci_fifo_state_type d;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid_i && !q.full;
  assign pop = out_ready_i && !q.empty;
  assign in_ready_o = !q.full;
  assign out_valid_o = !q.empty;
  assign out_data_o = q.mem[q.rd];

  // Pointer wrap handles depths that are not a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    unique case ({push, pop})
      2'b10: d.cnt = q.cnt + 1'b1;
      2'b01: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    d.full = (d.cnt == CW'(DEPTH));
    d.empty = (d.cnt == '0);
  end

  // Storage is not cleared, only the pointers, count and flags
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q.mem <= q.mem;
      q.wr <= '0;
      q.rd <= '0;
      q.cnt <= '0;
      q.full <= 1'b0;
      q.empty <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : hci_fifo

// What this block does
// - Host remote commands arrive only as a byte stream over the USB data link.
// - Escape, T, four-character code, carriage return acts as a keypad key press.
// - Escape, A, four-character code, carriage return asks for display or measurement output.
// - Escape, S, four-character code, carriage return selects a special system function.
// - Codes 0100, 0104, 0140 act as cancel, confirm and menu keys.
// - Codes 0135 to 0138 act as left, right, up, down arrows.
// - Codes 0109, 0110, 0111 act as first, second, third axis keys.
// - Codes 0141 to 0144 are unit, abs/inc, dia/rad keys and help.
// - Code 0145 enables evaluation of encoder reference marks like the local key.
// - Output code 0000 returns device identification to the host.
// - Output code 0200 returns present axis positions to the host.
// - Special code 0000 performs a full device reset.
// - Special code 0001 locks the local keypad; physical presses are ignored.
// - Special code 0002 releases the keypad lock, restoring physical key handling.
// - Single Ctrl-B character sends current axis positions without escape framing.
// - Single Ctrl-P character sends a capture of the present screen.
module hci_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic evt_ready_i,
  input wire logic local_key_valid_i,
  input wire hci_pkg::hci_key_type local_key_i,
  output hci_pkg::hci_key_evt_type key_evt_o,
  output hci_pkg::hci_req_type req_o,
  output logic keypad_locked_o
);

  typedef struct packed {
    hci_pkg::hci_state_type st;
    logic [7:0] cls;
    logic [31:0] code;
    logic [1:0] idx;
    logic locked;
    hci_pkg::hci_key_evt_type key;
    hci_pkg::hci_req_type req;
  } hci_core_state_type;

  typedef struct packed {
    logic hit;
    hci_pkg::hci_key_type key;
  } hci_key_hit_type;

  hci_core_state_type q;
  hci_core_state_type d;
  logic [7:0] byte_data;
  logic byte_valid;
  logic fifo_in_ready;
  logic take;

  // link byte path
  // Parser stalls when the event consumer is not ready, so the FIFO fills
  hci_fifo #(
    .WIDTH(hci_pkg::HCI_BYTE_W),
    .DEPTH(hci_pkg::HCI_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_data_i(rx_data_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(fifo_in_ready),
    .out_data_o(byte_data),
    .out_valid_o(byte_valid),
    .out_ready_i(evt_ready_i)
  );

  assign take = byte_valid && evt_ready_i;

  // Key code lookup; a miss means an unknown key code
  function automatic hci_key_hit_type key_lookup(input logic [31:0] code);
    hci_key_hit_type r;
    r.hit = 1'b1;
    r.key = hci_pkg::HCI_KEY_CANCEL;
    unique case (code)
      hci_pkg::HCI_KC_CANCEL: r.key = hci_pkg::HCI_KEY_CANCEL;
      hci_pkg::HCI_KC_CONFIRM: r.key = hci_pkg::HCI_KEY_CONFIRM;
      hci_pkg::HCI_KC_MENU: r.key = hci_pkg::HCI_KEY_MENU;
      hci_pkg::HCI_KC_LEFT: r.key = hci_pkg::HCI_KEY_LEFT;
      hci_pkg::HCI_KC_RIGHT: r.key = hci_pkg::HCI_KEY_RIGHT;
      hci_pkg::HCI_KC_UP: r.key = hci_pkg::HCI_KEY_UP;
      hci_pkg::HCI_KC_DOWN: r.key = hci_pkg::HCI_KEY_DOWN;
      hci_pkg::HCI_KC_AXIS1: r.key = hci_pkg::HCI_KEY_AXIS1;
      hci_pkg::HCI_KC_AXIS2: r.key = hci_pkg::HCI_KEY_AXIS2;
      hci_pkg::HCI_KC_AXIS3: r.key = hci_pkg::HCI_KEY_AXIS3;
      hci_pkg::HCI_KC_UNIT: r.key = hci_pkg::HCI_KEY_UNIT_SYSTEM_TOGGLE;
      hci_pkg::HCI_KC_ABS_INC: r.key = hci_pkg::HCI_KEY_ABS_INC;
      hci_pkg::HCI_KC_DIA_RAD: r.key = hci_pkg::HCI_KEY_DIA_RAD;
      hci_pkg::HCI_KC_HELP: r.key = hci_pkg::HCI_KEY_HELP;
      hci_pkg::HCI_KC_REF: r.key = hci_pkg::HCI_KEY_REF_MARKS;
      default: r.hit = 1'b0;
    endcase
    return r;
  endfunction : key_lookup

  // Frame parser, command decode and keypad lock
  always_comb begin
    hci_key_hit_type hit;
    hit = '0;
    d = q;
    d.key.valid = 1'b0;
    d.req = '0;
    if (take) begin
      if (byte_data == hci_pkg::HCI_CH_ESC) begin
        d.st = hci_pkg::HCI_ST_CLASS;
        d.req.frame_err = (q.st != hci_pkg::HCI_ST_IDLE);
      end else begin
        unique case (q.st)
          hci_pkg::HCI_ST_IDLE: begin
            if (byte_data == hci_pkg::HCI_CH_CTRL_B) begin
              d.req.position = 1'b1;
            end
            if (byte_data == hci_pkg::HCI_CH_CTRL_P) begin
              d.req.screen = 1'b1;
            end
          end
          hci_pkg::HCI_ST_CLASS: begin
            d.cls = byte_data;
            d.idx = '0;
            if (byte_data == hci_pkg::HCI_CLS_KEY || byte_data == hci_pkg::HCI_CLS_OUT ||
                byte_data == hci_pkg::HCI_CLS_SYS) begin
              d.st = hci_pkg::HCI_ST_CODE;
            end else begin
              d.st = hci_pkg::HCI_ST_IDLE;
              d.req.frame_err = 1'b1;
            end
          end
          hci_pkg::HCI_ST_CODE: begin
            d.code = {q.code[23:0], byte_data};
            d.idx = q.idx + 1'b1;
            if (q.idx == hci_pkg::HCI_CODE_LAST) begin
              d.st = hci_pkg::HCI_ST_TERM;
            end
          end
          hci_pkg::HCI_ST_TERM: begin
            d.st = hci_pkg::HCI_ST_IDLE;
            if (byte_data != hci_pkg::HCI_CH_CR) begin
              d.req.frame_err = 1'b1;
            end else if (q.cls == hci_pkg::HCI_CLS_KEY) begin
              hit = key_lookup(q.code);
              d.key.valid = hit.hit;
              d.key.from_host = 1'b1;
              d.key.key = hit.key;
              d.req.frame_err = !hit.hit;
            end else if (q.cls == hci_pkg::HCI_CLS_OUT) begin
              unique case (q.code)
                hci_pkg::HCI_OC_IDENT: d.req.ident = 1'b1;
                hci_pkg::HCI_OC_POS: d.req.position = 1'b1;
                default: d.req.frame_err = 1'b1;
              endcase
            end else begin
              unique case (q.code)
                hci_pkg::HCI_SC_RESET: begin
                  d.req.dev_reset = 1'b1;
                  d.locked = hci_pkg::HCI_LOCK_RST;
                end
                hci_pkg::HCI_SC_LOCK: d.locked = 1'b1;
                hci_pkg::HCI_SC_RELEASE: d.locked = 1'b0;
                default: d.req.frame_err = 1'b1;
              endcase
            end
          end
          default: d.st = hci_pkg::HCI_ST_IDLE;
        endcase
      end
    end
    // lock gates local keys only
    // Host keys win a same-cycle collision; the local press is dropped
    if (!d.key.valid && local_key_valid_i && !q.locked) begin
      d.key.valid = 1'b1;
      d.key.from_host = 1'b0;
      d.key.key = local_key_i;
    end
  end

  // All outputs are registered state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q.st <= hci_pkg::HCI_ST_IDLE;
      q.cls <= 8'h00;
      q.code <= 32'h00000000;
      q.idx <= 2'h0;
      q.locked <= hci_pkg::HCI_LOCK_RST;
      q.key <= '0;
      q.req <= '0;
    end else begin
      q <= d;
    end
  end

  // Ready is the FIFO's registered not-full flag itself; a delayed copy
  // would show ready for one cycle after filling and a byte would be lost
  assign rx_ready_o = fifo_in_ready;
  assign key_evt_o = q.key;
  assign req_o = q.req;
  assign keypad_locked_o = q.locked;

endmodule : hci_core

/* bench/hci_core_chk.sv */
`timescale 1ns/1ns
// Port watcher for the parser; all outputs registered
module hci_core_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire logic evt_ready_i,
  input wire logic local_key_valid_i,
  input wire hci_pkg::hci_key_type local_key_i,
  input wire hci_pkg::hci_key_evt_type key_evt_o,
  input wire hci_pkg::hci_req_type req_o,
  input wire logic keypad_locked_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Reset is the cause here, so it cannot also disable
  property p_reset_quiet;
    @(posedge core_clk_i) disable iff (1'b0)
    rst_i |=> !key_evt_o.valid && req_o == 5'h00 && !keypad_locked_o && rx_ready_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_local_key;
    local_key_valid_i && !keypad_locked_o |=> key_evt_o.valid &&
      (key_evt_o.from_host || key_evt_o.key == $past(local_key_i));
  endproperty
  a_local_key: assert property (p_local_key) else $error("local key lost");
  property p_lock_blocks;
    local_key_valid_i && keypad_locked_o |=> !(key_evt_o.valid && !key_evt_o.from_host);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked key passed");
  // An ident request needs a seven byte frame, so never two in a row
  property p_ident_pulse;
    req_o.ident |=> !req_o.ident [*2];
  endproperty
  a_ident_pulse: assert property (p_ident_pulse) else $error("ident not a pulse");
  property p_reset_unlock;
    req_o.dev_reset |-> ##[0:1] !keypad_locked_o;
  endproperty
  a_reset_unlock: assert property (p_reset_unlock) else $error("lock kept");
  property p_stall;
    !evt_ready_i |=> !(key_evt_o.valid && key_evt_o.from_host) && req_o == 5'h00;
  endproperty
  a_stall: assert property (p_stall) else $error("output while stalled");
  property p_full_holds;
    $fell(rx_ready_o) && !evt_ready_i |=> !rx_ready_o;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("full buffer reopened");
  property p_one_result;
    $onehot0({req_o, key_evt_o.valid & key_evt_o.from_host});
  endproperty
  a_one_result: assert property (p_one_result) else $error("two results at once");
endmodule : hci_core_chk

/* bench/hci_host_model.sv */
`timescale 1ns/1ns
// Host end of the link: offers bytes, holds each until taken
module hci_host_model (
  input wire logic core_clk_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  // Idle line at start
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // link only, whole frames
  // A byte counts as taken only at an edge where ready was sampled high
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge core_clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = b[i];
      do @(posedge core_clk_i); while (!rx_ready_i);
    end
    @(negedge core_clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o; // No stale byte on a released line
  endtask : send
endmodule : hci_host_model

/* bench/host_command_interpreter_tb.sv */
`timescale 1ns/1ns
module host_command_interpreter_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic locked;
  logic evt_ready = 1'b1;
  logic lkv = 1'b0;
  hci_pkg::hci_key_type lk = hci_pkg::HCI_KEY_CANCEL;
  hci_pkg::hci_key_evt_type key_evt;
  hci_pkg::hci_key_evt_type ev;
  hci_pkg::hci_req_type req;
  hci_pkg::hci_req_type rq;
  int failures = 0;
  int n_tests = 0;
  // Key codes in the order of the key enum
  logic [31:0] codes [15] = '{"0100", "0104", "0109", "0110", "0111", "0135", "0136",
    "0137", "0138", "0140", "0141", "0142", "0143", "0144", "0145"};
  // Clock, 50 ns period
  always #25 clk = ~clk;
  hci_core u_dut (.core_clk_i(clk), .rst_i(rst), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .evt_ready_i(evt_ready),
    .local_key_valid_i(lkv), .local_key_i(lk), .key_evt_o(key_evt), .req_o(req),
    .keypad_locked_o(locked));
  hci_host_model u_host (.core_clk_i(clk), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_evt(input hci_pkg::hci_key_evt_type g, e);
    n_tests++;
    if (g !== e) fail("key event");
  endtask : chk_evt
  task automatic chk_v(input logic [4:0] g, e, input string m);
    n_tests++;
    if (g !== e) fail(m);
  endtask : chk_v
  task automatic key_is(input logic fh, input hci_pkg::hci_key_type k);
    chk_evt(ev, '{1'b1, fh, k});
  endtask : key_is
  // Bounded wait for the next event or request pulse
  task automatic wait_out();
    bit got;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge clk);
      if (key_evt.valid === 1'b1 || req != 5'h00) begin
        got = 1'b1;
        ev = key_evt;
        rq = req;
      end
    end
    if (!got) fail("no output");
  endtask : wait_out
  task automatic frame(input logic [7:0] c, input logic [31:0] k, input logic [7:0] t);
    u_host.send('{8'h1B, c, k[31:24], k[23:16], k[15:8], k[7:0], t});
  endtask : frame
  // Class 00 sends terminator byte alone, as a control character
  task automatic req_case(input logic [7:0] c, input logic [31:0] k, input logic [7:0] t,
                          input logic [4:0] e);
    // Watch while sending: a bad class answers before the frame ends
    fork
      if (c == 8'h00) u_host.send('{t});
      else frame(c, k, t);
      wait_out();
    join
    chk_v(rq, e, "request");
  endtask : req_case
  task automatic press(input hci_pkg::hci_key_type k);
    @(negedge clk);
    lkv = 1'b1;
    lk = k;
    @(negedge clk);
    lkv = 1'b0;
    ev = key_evt;
  endtask : press
  task automatic set_sys(input logic [31:0] k);
    frame(8'h53, k, 8'h0D);
    repeat (4) @(negedge clk);
  endtask : set_sys
  task automatic t_keys();
    for (int i = 0; i < 15; i++) begin
      frame(8'h54, codes[i], 8'h0D);
      wait_out();
      key_is(1'b1, hci_pkg::hci_key_type'(i));
    end
  endtask : t_keys
  task automatic t_reqs();
    req_case(8'h41, "0000", 8'h0D, 5'h10);
    req_case(8'h41, "0200", 8'h0D, 5'h08);
    req_case(8'h00, 32'h0, 8'h02, 5'h08);
    req_case(8'h00, 32'h0, 8'h10, 5'h04);
    req_case(8'h5A, "0100", 8'h0D, 5'h01);
    req_case(8'h54, "9999", 8'h0D, 5'h01);
    req_case(8'h53, "0005", 8'h0D, 5'h01);
    req_case(8'h41, "0000", 8'h20, 5'h01);
    req_case(8'h41, "0000", 8'h0D, 5'h10);
  endtask : t_reqs
  task automatic t_lock();
    set_sys("0001");
    chk_v({4'h0, locked}, 5'h01, "lock");
    press(hci_pkg::HCI_KEY_MENU);
    chk_v({4'h0, ev.valid}, 5'h00, "locked key");
    frame(8'h54, "0104", 8'h0D);
    wait_out();
    key_is(1'b1, hci_pkg::HCI_KEY_CONFIRM);
    chk_v({4'h0, locked}, 5'h01, "lock kept");
    set_sys("0002");
    chk_v({4'h0, locked}, 5'h00, "release");
    press(hci_pkg::HCI_KEY_UP);
    key_is(1'b0, hci_pkg::HCI_KEY_UP);
    set_sys("0001");
    req_case(8'h53, "0000", 8'h0D, 5'h02);
    chk_v({4'h0, locked}, 5'h00, "reset unlock");
  endtask : t_lock
  // Stall the parser, fill all eight places, then drain
  task automatic t_fill();
    evt_ready = 1'b0;
    u_host.send('{8'h1B, 8'h41, 8'h30, 8'h32, 8'h30, 8'h30, 8'h0D, 8'h10});
    repeat (2) @(negedge clk);
    chk_v({4'h0, rx_ready}, 5'h00, "full");
    evt_ready = 1'b1;
    wait_out();
    chk_v(rq, 5'h08, "position");
    wait_out();
    chk_v(rq, 5'h04, "screen");
    repeat (3) @(negedge clk);
    chk_v({4'h0, rx_ready}, 5'h01, "drained");
  endtask : t_fill
  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_keys();
    t_reqs();
    t_lock();
    t_fill();
    end_of_test();
  end
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail("timeout");
    end_of_test();
  end
endmodule : host_command_interpreter_tb
bind hci_core hci_core_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
  .evt_ready_i(evt_ready_i), .local_key_valid_i(local_key_valid_i),
  .local_key_i(local_key_i), .key_evt_o(key_evt_o), .req_o(req_o),
  .keypad_locked_o(keypad_locked_o));
